// ===== load_store_addressing_unit.sv
`include "lsu_defs.svh"
module load_store_addressing_unit
	import lsu_pkg::*;
#(
	parameter int ADDR_W = 32
)(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_valid,
	input wire addr_mode_t i_mode,
	input wire logic i_load,
	input wire logic i_pair,
	input wire xfer_size_t i_size,
	input wire logic [3:0] i_transfer_register,
	input wire logic [3:0] i_second_transfer_register,
	input wire logic [31:0] i_base_value,
	input wire logic [31:0] i_offset_value,
	input wire logic [1:0] i_offset_left_shift,
	input wire logic [7:0] i_unpriv_offset,
	input wire logic i_unpriv_subtract,
	input wire logic [31:0] i_program_counter,
	input wire logic [12:0] i_pc_offset,
	input wire logic i_pc_subtract,
	input wire logic [31:0] i_store_value,
	input wire logic i_privileged,
	input wire logic [3:0] i_flags_in,
	input wire logic i_mem_done,
	input wire logic [31:0] i_mem_rdata,
	output logic o_busy,
	output logic o_mem_req,
	output logic o_mem_write,
	output logic [ADDR_W-1:0] o_mem_addr,
	output logic [31:0] o_mem_wdata,
	output logic [3:0] o_mem_strobe,
	output logic o_mem_unpriv,
	output logic o_wb_en,
	output logic [3:0] o_wb_reg,
	output logic [31:0] o_wb_data,
	output logic o_branch,
	output logic [31:0] o_branch_target,
	output logic o_offset_error,
	output logic [3:0] o_flags_out
);
	lsu_state_t state, next_state;
	logic mem_req, next_mem_req, mem_write, next_mem_write, mem_unpriv, next_mem_unpriv;
	logic [ADDR_W-1:0] mem_addr, next_mem_addr;
	logic [31:0] mem_wdata, next_mem_wdata, wb_data, next_wb_data, br_tgt, next_br_tgt;
	logic [3:0] mem_strobe, next_mem_strobe, wb_reg, next_wb_reg, rt2, next_rt2, flags, next_flags;
	logic wb_en, next_wb_en, branch, next_branch, ofs_err, next_ofs_err, is_load, next_is_load;
	xfer_size_t size, next_size;
	logic [31:0] ea, load_value, store_data;
	logic [3:0] strobe;

	// Signed add or subtract of a magnitude to a base
	function automatic logic [31:0] offset_add(input logic [31:0] base, input logic [31:0] mag,
		input logic sub);
		offset_add = sub ? base - mag : base + mag;
	endfunction

	// Effective address per mode; base itself is left untouched
	always_comb begin
		case (i_mode)
			MODE_REG_OFS: ea = i_base_value + (i_offset_value << i_offset_left_shift);
			MODE_UNPRIV: ea = offset_add(i_base_value, {24'h000000, i_unpriv_offset}, i_unpriv_subtract);
			MODE_PC_REL: ea = offset_add(i_program_counter, {19'h00000, i_pc_offset}, i_pc_subtract);
			default: ea = i_base_value;
		endcase
	end

	lsu_data_sizer u_sizer (
		.i_size(state == ST_IDLE ? i_size : size),
		.i_lane(state == ST_IDLE ? ea[1:0] : mem_addr[1:0]),
		.i_rdata(i_mem_rdata),
		.i_wsrc(i_store_value),
		.o_load_value(load_value),
		.o_store_data(store_data),
		.o_strobe(strobe)
	);

	// Sequencer: issue, wait, optional second word of a pair
	always_comb begin
		next_state = state;
		next_mem_req = mem_req;
		next_mem_write = mem_write;
		next_mem_unpriv = mem_unpriv;
		next_mem_addr = mem_addr;
		next_mem_wdata = mem_wdata;
		next_mem_strobe = mem_strobe;
		next_wb_en = 1'b0;
		next_wb_reg = wb_reg;
		next_wb_data = wb_data;
		next_branch = 1'b0;
		next_br_tgt = br_tgt;
		next_ofs_err = 1'b0;
		next_rt2 = rt2;
		next_size = size;
		next_is_load = is_load;
		next_flags = flags;
		case (state)
			ST_IDLE: begin
				next_flags = i_flags_in;
				if (i_valid) begin
					if (i_mode == MODE_PC_REL && (i_pair ? (i_pc_offset > `LSU_PAIR_MAX)
						: (i_pc_offset > `LSU_PCREL_MAX))) begin
						next_ofs_err = 1'b1;
					end else begin
						next_state = ST_WAIT;
						next_mem_req = 1'b1;
						next_is_load = i_load | (i_mode == MODE_PC_REL);
						next_mem_write = ~next_is_load;
						next_mem_unpriv = (i_mode == MODE_UNPRIV) | ~i_privileged;
						next_mem_addr = ea[ADDR_W-1:0];
						next_size = (i_mode == MODE_PC_REL && i_pair) ? SIZE_WORD : i_size;
						next_mem_wdata = store_data;
						next_mem_strobe = next_is_load ? 4'hf : strobe;
						next_wb_reg = i_transfer_register;
						next_rt2 = (i_mode == MODE_PC_REL && i_pair) ? i_second_transfer_register
							: `LSU_REG_PC;
					end
				end
			end
			ST_WAIT, ST_WAIT2: begin
				if (i_mem_done) begin
					next_mem_req = 1'b0;
					next_state = ST_IDLE;
					if (is_load) begin
						if (wb_reg == `LSU_REG_PC && size == SIZE_WORD) begin
							next_branch = 1'b1;
							next_br_tgt = {i_mem_rdata[31:1], 1'b0};
						end else begin
							next_wb_en = 1'b1;
							next_wb_data = load_value;
						end
						if (state == ST_WAIT && rt2 != `LSU_REG_PC) begin
							next_state = ST_SECOND;
						end
					end
				end
			end
			ST_SECOND: begin
				next_state = ST_WAIT2;
				next_mem_req = 1'b1;
				next_mem_addr = ADDR_W'(mem_addr + `LSU_PAIR_STEP);
				next_wb_reg = rt2;
				next_rt2 = `LSU_REG_PC;
			end
			default: next_state = ST_IDLE;
		endcase
	end

	// State registers
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			state <= ST_IDLE;
			mem_req <= 1'b0;
			mem_write <= 1'b0;
			mem_unpriv <= 1'b0;
			mem_addr <= '0;
			mem_wdata <= 32'h00000000;
			mem_strobe <= 4'h0;
			wb_en <= 1'b0;
			wb_reg <= 4'h0;
			wb_data <= 32'h00000000;
			branch <= 1'b0;
			br_tgt <= 32'h00000000;
			ofs_err <= 1'b0;
			rt2 <= `LSU_REG_PC;
			size <= SIZE_WORD;
			is_load <= 1'b0;
			flags <= 4'h0;
		end else begin
			state <= next_state;
			mem_req <= next_mem_req;
			mem_write <= next_mem_write;
			mem_unpriv <= next_mem_unpriv;
			mem_addr <= next_mem_addr;
			mem_wdata <= next_mem_wdata;
			mem_strobe <= next_mem_strobe;
			wb_en <= next_wb_en;
			wb_reg <= next_wb_reg;
			wb_data <= next_wb_data;
			branch <= next_branch;
			br_tgt <= next_br_tgt;
			ofs_err <= next_ofs_err;
			rt2 <= next_rt2;
			size <= next_size;
			is_load <= next_is_load;
			flags <= next_flags;
		end
	end

	assign o_busy = mem_req;
	assign o_mem_req = mem_req;
	assign o_mem_write = mem_write;
	assign o_mem_addr = mem_addr;
	assign o_mem_wdata = mem_wdata;
	assign o_mem_strobe = mem_strobe;
	assign o_mem_unpriv = mem_unpriv;
	assign o_wb_en = wb_en;
	assign o_wb_reg = wb_reg;
	assign o_wb_data = wb_data;
	assign o_branch = branch;
	assign o_branch_target = br_tgt;
	assign o_offset_error = ofs_err;
	assign o_flags_out = flags;

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	sequence s_issue_unpriv;
		state == ST_IDLE && i_valid && i_mode == MODE_UNPRIV;
	endsequence
	sequence s_pair_issue;
		state == ST_IDLE && i_valid && i_mode == MODE_PC_REL && i_pair && i_pc_offset <= `LSU_PAIR_MAX;
	endsequence
	// First word of a pair returned, second still owed
	sequence s_first_word_done;
		state == ST_WAIT && i_mem_done && is_load && rt2 != `LSU_REG_PC;
	endsequence
	// Gap cycle, then the second word goes out four bytes higher
	sequence s_second_word_issue;
		state == ST_SECOND ##1 (state == ST_WAIT2 && o_mem_req && o_wb_reg == $past(rt2, 2)
			&& o_mem_addr == $past(o_mem_addr) + `LSU_PAIR_STEP);
	endsequence

	a_reg_ofs_addr: assert property (state == ST_IDLE && i_valid && i_mode == MODE_REG_OFS |=>
		mem_addr == $past(i_base_value) + ($past(i_offset_value) << $past(i_offset_left_shift)))
		else $error("register offset address wrong");
	a_unpriv_access: assert property (s_issue_unpriv |=> o_mem_unpriv && o_mem_req)
		else $error("unprivileged access not forced");
	a_priv_normal: assert property (state == ST_IDLE && i_valid && i_mode == MODE_REG_OFS && i_privileged
		|=> !o_mem_unpriv) else $error("privileged access wrongly demoted");
	a_pc_range: assert property (state == ST_IDLE && i_valid && i_mode == MODE_PC_REL && !i_pair
		&& i_pc_offset > `LSU_PCREL_MAX |=> o_offset_error && !o_mem_req) else $error("offset range not checked");
	a_pair_regs: assert property (s_pair_issue |=> o_mem_req && !o_mem_write
		&& o_wb_reg == $past(i_transfer_register) && rt2 == $past(i_second_transfer_register))
		else $error("pair registers not captured");
	a_pair_two_wb: assert property (s_first_word_done |=> s_second_word_issue)
		else $error("second pair word not issued");
	a_flags_hold: assert property (state != ST_IDLE |=> o_flags_out == $past(o_flags_out))
		else $error("flags changed during access");
	a_branch_even: assert property (o_branch |-> o_branch_target[0] == 1'b0 && !o_wb_en)
		else $error("branch target not halfword aligned");
	a_byte_lane: assert property (o_mem_req && o_mem_write && size == SIZE_BYTE |->
		$onehot(o_mem_strobe) && o_mem_strobe == (4'h1 << o_mem_addr[1:0])) else $error("byte strobe wrong");
	a_zero_ext: assert property (o_wb_en && size == SIZE_BYTE && is_load |-> o_wb_data[31:8] == 24'h000000)
		else $error("byte load not zero extended");
	a_no_base_wb: assert property (o_wb_en |-> o_wb_reg == $past(wb_reg)
		&& $past(is_load && i_mem_done && (state == ST_WAIT || state == ST_WAIT2)))
		else $error("register written without a load");
endmodule

// ===== lsu_defs.svh
`ifndef LSU_DEFS_SVH
`define LSU_DEFS_SVH
`define LSU_SHIFT_MAX 2'd3
`define LSU_UNPRIV_OFS_MAX 8'hff
`define LSU_PCREL_MAX 13'h0fff
`define LSU_PAIR_MAX 13'h03fc
`define LSU_PAIR_STEP 32'h0000_0004
`define LSU_REG_PC 4'hf
`define LSU_REG_SP 4'hd
`endif

// ===== lsu_pkg.sv
package lsu_pkg;
	typedef enum logic [1:0] {
		MODE_REG_OFS = 2'b00,
		MODE_UNPRIV = 2'b01,
		MODE_PC_REL = 2'b10
	} addr_mode_t;
	typedef enum logic [2:0] {
		SIZE_WORD = 3'b000,
		SIZE_BYTE = 3'b001,
		SIZE_HALF = 3'b010,
		SIZE_SIGNED_OCTET = 3'b011,
		SIZE_SIGNED_16 = 3'b100
	} xfer_size_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_SECOND = 2'b10,
		ST_WAIT2 = 2'b11
	} lsu_state_t;
endpackage

// ===== lsu_data_sizer.sv
`include "lsu_defs.svh"
module lsu_data_sizer
	import lsu_pkg::*;
(
	input wire xfer_size_t i_size,
	input wire logic [1:0] i_lane,
	input wire logic [31:0] i_rdata,
	input wire logic [31:0] i_wsrc,
	output logic [31:0] o_load_value,
	output logic [31:0] o_store_data,
	output logic [3:0] o_strobe
);
	logic [7:0] octet;
	logic [15:0] half;
	// Pick the addressed lane out of the read word
	always_comb begin
		octet = i_rdata[{i_lane, 3'b000} +: 8];
		half = i_lane[1] ? i_rdata[31:16] : i_rdata[15:0];
		o_load_value = i_rdata;
		o_store_data = i_wsrc;
		o_strobe = 4'hf;
		case (i_size)
			SIZE_BYTE: begin
				o_load_value = {24'h000000, octet};
				o_store_data = {4{i_wsrc[7:0]}};
				o_strobe = 4'h1 << i_lane;
			end
			SIZE_HALF: begin
				o_load_value = {16'h0000, half};
				o_store_data = {2{i_wsrc[15:0]}};
				o_strobe = i_lane[1] ? 4'hc : 4'h3;
			end
			SIZE_SIGNED_OCTET: o_load_value = {{24{octet[7]}}, octet};
			SIZE_SIGNED_16: o_load_value = {{16{half[15]}}, half};
			default: begin
				o_load_value = i_rdata;
			end
		endcase
	end
endmodule

// ===== mem_model.sv
module mem_model(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_req,
	input wire logic i_slow,
	input wire logic [31:0] i_addr,
	output logic o_done,
	output logic [31:0] o_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] cnt;
	// Answers after 0 or 4 wait cycles with the inverted address
	always @(posedge i_sys_clk) begin
		o_done <= 1'b0;
		o_rdata <= ~o_rdata; // Released data bus keeps toggling
		if (i_rst) begin
			cnt <= 3'h0;
			o_rdata <= 32'h0;
		end else if (o_done || !i_req)
			cnt <= 3'h0;
		else if (cnt == (i_slow ? 3'h4 : 3'h0)) begin
			o_done <= 1'b1;
			o_rdata <= ~i_addr;
		end else
			cnt <= cnt + 3'h1;
	end
endmodule

// ===== tb_top.sv
module tb_top
	import lsu_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0, rst = 1'b1, vld, ld, pr, usub, psub, priv, slow, done, busy, req, wr, up, wbe, br, oerr;
	logic lup, lwr;
	addr_mode_t mode;
	xfer_size_t size;
	logic [1:0] shl;
	logic [3:0] rt, rt2, flg, stb, wreg, fout, lstb;
	logic [7:0] uofs;
	logic [12:0] pofs;
	logic [31:0] base, ofs, pc, wsrc, rdata, maddr, wdat, wbd, tgt, e, lwd, btgt;
	logic [31:0] aq[$], dq[$];
	logic [3:0] rq[$];
	int fail_count = 0, cmp_count = 0, cyc = 0, evt = 0, brs, errs;
	always #5 clk = ~clk;
	load_store_addressing_unit dut_u(.i_sys_clk(clk), .i_rst(rst), .i_valid(vld), .i_mode(mode), .i_load(ld),
		.i_pair(pr), .i_size(size), .i_transfer_register(rt), .i_second_transfer_register(rt2), .i_base_value(base),
		.i_offset_value(ofs), .i_offset_left_shift(shl), .i_unpriv_offset(uofs), .i_unpriv_subtract(usub),
		.i_program_counter(pc), .i_pc_offset(pofs), .i_pc_subtract(psub), .i_store_value(wsrc), .i_privileged(priv),
		.i_flags_in(flg), .i_mem_done(done), .i_mem_rdata(rdata), .o_busy(busy), .o_mem_req(req), .o_mem_write(wr),
		.o_mem_addr(maddr), .o_mem_wdata(wdat), .o_mem_strobe(stb), .o_mem_unpriv(up), .o_wb_en(wbe), .o_wb_reg(wreg),
		.o_wb_data(wbd), .o_branch(br), .o_branch_target(tgt), .o_offset_error(oerr), .o_flags_out(fout));
	mem_model mem_u(.i_sys_clk(clk), .i_rst(rst), .i_req(req), .i_slow(slow), .i_addr(maddr), .o_done(done),
		.o_rdata(rdata));
	// Records accesses, write-backs, branches and errors
	always @(posedge clk) begin
		cyc++;
		if (req && done) begin
			aq.push_back(maddr);
			{lwd, lstb, lup, lwr} = {wdat, stb, up, wr};
			chk("busy", 32'h1, {31'h0, busy});
			evt += 32'(wr);
		end
		if (wbe) begin
			dq.push_back(wbd);
			rq.push_back(wreg);
		end
		btgt = br ? tgt : btgt;
		brs += 32'(br);
		errs += 32'(oerr);
		evt += 32'(wbe) + 32'(br) + 32'(oerr);
		if (cyc == 3000) begin
			fail_count++;
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Expected load value after lane pick and extension
	function automatic logic [31:0] ext(input xfer_size_t s, input logic [31:0] d, input logic [1:0] ln);
		logic [31:0] v;
		v = d >> (8 * ln);
		case (s)
			SIZE_BYTE: ext = {24'h0, v[7:0]};
			SIZE_HALF: ext = {16'h0, v[15:0]};
			SIZE_SIGNED_OCTET: ext = {{24{v[7]}}, v[7:0]};
			SIZE_SIGNED_16: ext = {{16{v[15]}}, v[15:0]};
			default: ext = d;
		endcase
	endfunction
	task automatic op(input addr_mode_t m, input logic l, input logic p, input xfer_size_t s,
		input logic [31:0] b, input logic [31:0] o, input logic [3:0] r);
		mode <= m;
		ld <= l;
		pr <= p;
		size <= s;
		base <= b;
		ofs <= o;
		rt <= r;
	endtask
	// Issues one instruction and waits for its events
	task automatic go(input int need);
		int stop;
		stop = evt + need;
		aq.delete();
		dq.delete();
		rq.delete();
		brs = 0;
		errs = 0;
		@(posedge clk) vld <= 1'b1;
		@(posedge clk) vld <= 1'b0;
		for (int i = 0; i < 40 && evt < stop; i++)
			@(posedge clk);
		repeat (3) @(posedge clk);
		chk("flags", {28'h0, flg}, {28'h0, fout});
		chk("idle", 32'h0, {31'h0, busy});
	endtask
	task automatic tally_and_finish();
		if (fail_count == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic t_shift();
		for (int s = 0; s < 4; s++) begin
			op(MODE_REG_OFS, 1'b1, 1'b0, SIZE_WORD, 32'h0000_1000, 32'h0000_0010, 4'hd);
			shl <= 2'(s);
			slow <= s[0];
			flg <= 4'(s + 5);
			e = 32'h0000_1000 + (32'h0000_0010 << s);
			go(1);
			chk("addr", e, aq[0]);
			chk("data", ~e, dq[0]);
			chk("unpriv", 32'h0, {31'h0, lup});
			chk("write", 32'h0, {31'h0, lwr});
		end
		shl <= 2'h0;
	endtask
	task automatic t_sizes();
		xfer_size_t sz [4] = '{SIZE_BYTE, SIZE_HALF, SIZE_SIGNED_OCTET, SIZE_SIGNED_16};
		for (int i = 0; i < 16; i++) begin
			if (i[2] && i[0])
				continue;
			op(MODE_REG_OFS, 1'b1, 1'b0, sz[i / 4], 32'h8000_7f00, 32'(i % 4), 4'h2);
			e = 32'h8000_7f00 + 32'(i % 4);
			go(1);
			chk("load", ext(sz[i / 4], ~e, e[1:0]), dq[0]);
			chk("lstrobe", 32'hf, {28'h0, lstb});
		end
	endtask
	task automatic t_store();
		for (int i = 0; i < 7; i++) begin
			e = 32'h0000_2000 + 32'(i < 4 ? i : i < 6 ? 2 * i - 8 : 0);
			op(MODE_REG_OFS, 1'b0, 1'b0, i < 4 ? SIZE_BYTE : i < 6 ? SIZE_HALF : SIZE_WORD, 32'h0000_2000,
				e - 32'h0000_2000, 4'h5);
			wsrc <= 32'h1122_3344;
			go(1);
			chk("write", 32'h1, {31'h0, lwr});
			chk("wdata", i < 4 ? 32'h4444_4444 : i < 6 ? 32'h3344_3344 : 32'h1122_3344, lwd);
			chk("strobe", {28'h0, i < 4 ? 4'h1 << e[1:0] : i < 6 ? 4'h3 << e[1:0] : 4'hf}, {28'h0, lstb});
		end
	endtask
	task automatic t_unpriv();
		logic [7:0] u [3] = '{8'hff, 8'h00, 8'h10};
		logic [31:0] a [3] = '{32'h0000_30ff, 32'h0000_3000, 32'h0000_2ff0};
		for (int i = 0; i < 3; i++) begin
			op(MODE_UNPRIV, 1'b1, 1'b0, SIZE_WORD, 32'h0000_3000, 32'h0, 4'h6);
			uofs <= u[i];
			usub <= i[1];
			priv <= 1'(i == 0);
			go(1);
			chk("addr", a[i], aq[0]);
			chk("unpriv", 32'h1, {31'h0, lup});
		end
		priv <= 1'b1;
	endtask
	task automatic t_pcrel();
		logic [12:0] o [5] = '{13'h0fff, 13'h0fff, 13'h1000, 13'h03fc, 13'h0400};
		for (int i = 0; i < 5; i++) begin
			op(MODE_PC_REL, 1'b1, 1'(i > 2), i == 3 ? SIZE_WORD : SIZE_SIGNED_OCTET, 32'h0, 32'h0, 4'h7);
			pofs <= o[i];
			psub <= 1'(i == 1);
			e = i == 1 ? 32'h0000_7001 : 32'h0000_8000 + 32'(o[i]);
			go(i == 3 ? 2 : 1);
			chk("err", 32'(i == 2 || i == 4), 32'(errs));
			if (i == 2 || i == 4)
				chk("noacc", 32'h0, 32'(aq.size()));
			else
				chk("load", i == 3 ? ~e : ext(SIZE_SIGNED_OCTET, ~e, e[1:0]), dq[0]);
			if (i == 3) begin
				chk("data2", ~e - 32'h4, dq[1]);
				chk("regs", 32'h78, {24'h0, rq[0], rq[1]});
			end
		end
	endtask
	task automatic t_pcload();
		op(MODE_REG_OFS, 1'b1, 1'b0, SIZE_WORD, 32'h0000_4000, 32'h0000_0004, 4'hf);
		go(1);
		chk("target", 32'hffff_bffa, btgt);
		chk("branch", 32'h1, 32'(brs));
		chk("nowb", 32'h0, 32'(dq.size()));
	endtask
	initial begin
		{vld, ld, pr, usub, psub, slow, shl, rt, flg, uofs, base, ofs, wsrc} = '0;
		{priv, rt2, pofs, pc} = {1'b1, 4'h8, 13'h0, 32'h0000_8000};
		mode = MODE_REG_OFS;
		size = SIZE_WORD;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_shift();
		t_sizes();
		t_store();
		t_unpriv();
		t_pcrel();
		t_pcload();
		tally_and_finish();
	end
endmodule
